// [shared/irqh_pkg.sv]
// shared constants and helpers for the three-level interrupt handler and core end
package irqh_pkg;
    localparam int SRC_COUNT = 24;
    localparam int GROUP_WIDTH = 8;
    localparam int ADDR_WIDTH = 12;
    localparam int DATA_WIDTH = 32;

    // interrupt number of bit 0 of each group
    localparam int HIGH_BASE = 16;
    localparam int MID_BASE = 8;
    localparam int LOW_BASE = 0;

    // handler register byte offsets
    localparam logic [11:0] OFS_FLAGS_HIGH = 12'h000;
    localparam logic [11:0] OFS_FLAGS_MID = 12'h004;
    localparam logic [11:0] OFS_FLAGS_LOW = 12'h008;
    localparam logic [11:0] OFS_EN_HIGH = 12'h00c;
    localparam logic [11:0] OFS_EN_MID = 12'h010;
    localparam logic [11:0] OFS_EN_LOW = 12'h014;
    localparam logic [11:0] OFS_CODE = 12'h018;
    localparam logic [11:0] OFS_ACTIVE = 12'h01c;

    // core end register byte offsets
    localparam logic [11:0] OFS_CORE_STAT = 12'h000;
    localparam logic [11:0] OFS_CORE_MASK = 12'h004;
    localparam logic [11:0] OFS_CORE_TAKEN = 12'h008;

    // bit positions in the group activity register
    localparam int ACT_HIGH_BIT = 2;
    localparam int ACT_MID_BIT = 1;
    localparam int ACT_LOW_BIT = 0;

    // reset values
    localparam logic [23:0] FLAGS_RESET = 24'h000000;
    localparam logic [23:0] ENABLES_RESET = 24'h000000;
    localparam logic [7:0] CODE_NONE = 8'hff;
    localparam logic [2:0] ACTIVE_RESET = 3'h0;
    localparam logic [2:0] LEVELS_RESET = 3'h0;
    localparam logic [31:0] DATA_ZERO = 32'h00000000;

    // fixed vector addresses of the three core levels (plain defaults)
    localparam logic [15:0] VECTOR_LEVEL_ZERO = 16'h0003;
    localparam logic [15:0] VECTOR_LEVEL_ONE = 16'h0001;
    localparam logic [15:0] VECTOR_LEVEL_TWO = 16'h0002;
    localparam logic [15:0] VECTOR_RESET = 16'h0000;

    typedef enum logic [0:0] {
        IRQH_IDLE = 1'b0,
        IRQH_BUSY = 1'b1
    } irqh_core_state_e;

    // true when an apb setup cycle is present
    function automatic logic irqh_setup(input logic psel, input logic penable);
        return psel & ~penable;
    endfunction

    // largest pending interrupt number, or none
    function automatic logic [7:0] irqh_top_code(input logic [23:0] f);
        logic [7:0] c;
        c = CODE_NONE;
        for (int i = 0; i < SRC_COUNT; i++) begin
            if (f[i]) begin
                c = 8'(i);
            end
        end
        return c;
    endfunction
endpackage

// [shared/irqh_if.sv]
// link between the interrupt handler and the cpu core end
`timescale 1ns/10ps
interface irqh_if;
    logic core_request_level_zero;
    logic core_request_level_one;
    logic core_request_level_two;

    modport handler (
        output core_request_level_zero,
        output core_request_level_one,
        output core_request_level_two
    );

    modport core (
        input core_request_level_zero,
        input core_request_level_one,
        input core_request_level_two
    );
endinterface

// [logic/irqh_handler.sv]
// interrupt handler: 24 sources, three flag groups, apb register slave
`timescale 1ns/10ps
module irqh_handler (
    input wire logic mclk,
    input wire logic rst_n,
    irqh_if.handler link,
    input wire logic [irqh_pkg::SRC_COUNT-1:0] sources,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [irqh_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [irqh_pkg::DATA_WIDTH-1:0] pwdata,
    output logic [irqh_pkg::DATA_WIDTH-1:0] prdata,
    output logic pready,
    output logic pslverr
);
    import irqh_pkg::*;

    logic [23:0] src_prev;
    logic [23:0] flags;
    logic [23:0] enables;
    logic [7:0] code;
    logic [2:0] active;
    logic [23:0] rise;
    logic [23:0] set_now;
    logic [23:0] clr_now;
    logic [23:0] next_flags;
    logic [23:0] next_enables;
    logic [23:0] req_flags;
    logic wr_access;
    logic setup;
    logic [31:0] next_rdata;
    logic next_err;

    // sources come from peripherals on mclk itself, sampled every edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            src_prev <= FLAGS_RESET;
        end else begin
            src_prev <= sources;
        end
    end

    assign rise = sources & ~src_prev;
    assign set_now = rise & enables;

    assign setup = irqh_setup(psel, penable);
    assign wr_access = psel & penable & pready & pwrite;

    // write-one-to-clear masks per group
    always_comb begin
        clr_now = FLAGS_RESET;
        if (wr_access) begin
            case (paddr)
                OFS_FLAGS_HIGH: begin
                    clr_now[HIGH_BASE +: GROUP_WIDTH] = pwdata[7:0];
                end
                OFS_FLAGS_MID: begin
                    clr_now[MID_BASE +: GROUP_WIDTH] = pwdata[7:0];
                end
                OFS_FLAGS_LOW: begin
                    clr_now[LOW_BASE +: GROUP_WIDTH] = pwdata[7:0];
                end
                default: begin
                    clr_now = FLAGS_RESET;
                end
            endcase
        end
    end

    // a new edge in the clearing cycle keeps its flag
    assign next_flags = (flags & ~clr_now) | set_now;
    assign req_flags = next_flags & enables;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flags <= FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    always_comb begin
        next_enables = enables;
        if (wr_access) begin
            case (paddr)
                OFS_EN_HIGH: begin
                    next_enables[HIGH_BASE +: GROUP_WIDTH] = pwdata[7:0];
                end
                OFS_EN_MID: begin
                    next_enables[MID_BASE +: GROUP_WIDTH] = pwdata[7:0];
                end
                OFS_EN_LOW: begin
                    next_enables[LOW_BASE +: GROUP_WIDTH] = pwdata[7:0];
                end
                default: begin
                    next_enables = enables;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            enables <= ENABLES_RESET;
        end else begin
            enables <= next_enables;
        end
    end

    // requests toward the core: high to zero, mid to one, low to two
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            link.core_request_level_zero <= 1'b0;
            link.core_request_level_one <= 1'b0;
            link.core_request_level_two <= 1'b0;
        end else begin
            // built from next_flags so the level rises one cycle after the source
            link.core_request_level_zero <= |req_flags[HIGH_BASE +: GROUP_WIDTH];
            link.core_request_level_one <= |req_flags[MID_BASE +: GROUP_WIDTH];
            link.core_request_level_two <= |req_flags[LOW_BASE +: GROUP_WIDTH];
        end
    end

    // highest pending code and group activity follow the flags
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            code <= CODE_NONE;
        end else begin
            code <= irqh_top_code(next_flags);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            active <= ACTIVE_RESET;
        end else begin
            active[ACT_HIGH_BIT] <= |next_flags[HIGH_BASE +: GROUP_WIDTH];
            active[ACT_MID_BIT] <= |next_flags[MID_BASE +: GROUP_WIDTH];
            active[ACT_LOW_BIT] <= |next_flags[LOW_BASE +: GROUP_WIDTH];
        end
    end

    // read mux, taken during the setup cycle
    always_comb begin
        next_rdata = DATA_ZERO;
        next_err = 1'b0;
        case (paddr)
            OFS_FLAGS_HIGH: begin
                next_rdata[7:0] = flags[HIGH_BASE +: GROUP_WIDTH];
            end
            OFS_FLAGS_MID: begin
                next_rdata[7:0] = flags[MID_BASE +: GROUP_WIDTH];
            end
            OFS_FLAGS_LOW: begin
                next_rdata[7:0] = flags[LOW_BASE +: GROUP_WIDTH];
            end
            OFS_EN_HIGH: begin
                next_rdata[7:0] = enables[HIGH_BASE +: GROUP_WIDTH];
            end
            OFS_EN_MID: begin
                next_rdata[7:0] = enables[MID_BASE +: GROUP_WIDTH];
            end
            OFS_EN_LOW: begin
                next_rdata[7:0] = enables[LOW_BASE +: GROUP_WIDTH];
            end
            OFS_CODE: begin
                next_rdata[7:0] = code;
            end
            OFS_ACTIVE: begin
                next_rdata[2:0] = active;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    // apb answer: pready in the first access cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata <= DATA_ZERO;
        end else if (setup && !pwrite) begin
            prdata <= next_rdata;
        end else if (setup) begin
            prdata <= DATA_ZERO;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup & next_err;
        end
    end
endmodule

// [logic/irqh_core.sv]
// cpu core end: latches level requests, takes them in fixed order, apb status
`timescale 1ns/10ps
module irqh_core (
    input wire logic mclk,
    input wire logic rst_n,
    irqh_if.core link,
    input wire logic ret_pulse,
    output logic take_pulse,
    output logic [15:0] vector_addr,
    output logic [1:0] taken_level,
    output logic in_service,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [irqh_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [irqh_pkg::DATA_WIDTH-1:0] pwdata,
    output logic [irqh_pkg::DATA_WIDTH-1:0] prdata,
    output logic pready,
    output logic pslverr
);
    import irqh_pkg::*;

    irqh_core_state_e state;
    logic [2:0] req;
    logic [2:0] req_prev;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [2:0] ready_lv;
    logic [2:0] clr_now;
    logic setup;
    logic wr_access;
    logic [31:0] next_rdata;
    logic next_err;

    assign req = {link.core_request_level_two, link.core_request_level_one,
                  link.core_request_level_zero};
    assign setup = irqh_setup(psel, penable);
    assign wr_access = psel & penable & pready & pwrite;
    assign clr_now = (wr_access && paddr == OFS_CORE_STAT) ? pwdata[2:0] : LEVELS_RESET;
    assign ready_lv = stat & mask;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            req_prev <= LEVELS_RESET;
        end else begin
            req_prev <= req;
        end
    end

    // status bit set on request edge, software clears; set wins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stat <= LEVELS_RESET;
        end else begin
            stat <= (stat & ~clr_now) | (req & ~req_prev);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mask <= LEVELS_RESET;
        end else if (wr_access && paddr == OFS_CORE_MASK) begin
            mask <= pwdata[2:0];
        end
    end

    // take one level at a time, level zero first
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= IRQH_IDLE;
            take_pulse <= 1'b0;
            vector_addr <= VECTOR_RESET;
            taken_level <= 2'h0;
            in_service <= 1'b0;
        end else begin
            take_pulse <= 1'b0;
            case (state)
                IRQH_IDLE: begin
                    if (ready_lv != LEVELS_RESET) begin
                        state <= IRQH_BUSY;
                        take_pulse <= 1'b1;
                        in_service <= 1'b1;
                        if (ready_lv[0]) begin
                            vector_addr <= VECTOR_LEVEL_ZERO;
                            taken_level <= 2'h0;
                        end else if (ready_lv[1]) begin
                            vector_addr <= VECTOR_LEVEL_ONE;
                            taken_level <= 2'h1;
                        end else begin
                            vector_addr <= VECTOR_LEVEL_TWO;
                            taken_level <= 2'h2;
                        end
                    end
                end
                IRQH_BUSY: begin
                    if (ret_pulse) begin
                        state <= IRQH_IDLE;
                        in_service <= 1'b0;
                    end
                end
                default: begin
                    state <= IRQH_IDLE;
                    in_service <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        next_rdata = DATA_ZERO;
        next_err = 1'b0;
        case (paddr)
            OFS_CORE_STAT: begin
                next_rdata[2:0] = stat;
            end
            OFS_CORE_MASK: begin
                next_rdata[2:0] = mask;
            end
            OFS_CORE_TAKEN: begin
                next_rdata[2:0] = {in_service, taken_level};
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= DATA_ZERO;
        end else begin
            pready <= setup;
            pslverr <= setup & next_err;
            if (setup) begin
                prdata <= pwrite ? DATA_ZERO : next_rdata;
            end
        end
    end
endmodule

// [tb/irqh_chk.sv]
// assertions on the level link and the handler bus answers
`timescale 1ns/10ps
module irqh_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic core_request_level_zero,
    input wire logic core_request_level_one,
    input wire logic core_request_level_two,
    input wire logic [irqh_pkg::SRC_COUNT-1:0] sources,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [irqh_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic take_pulse,
    input wire logic [15:0] vector_addr,
    input wire logic [1:0] taken_level
);
    import irqh_pkg::*;
    logic [SRC_COUNT-1:0] src_q;
    logic [SRC_COUNT-1:0] rise;
    logic [2:0] grp_rise;
    logic [2:0] wr_en;
    logic wr;
    assign rise = sources & ~src_q;
    assign grp_rise = {|rise[23:16], |rise[15:8], |rise[7:0]};
    assign wr = psel & penable & pwrite & pready;
    assign wr_en = {wr && paddr == OFS_EN_HIGH, wr && paddr == OFS_EN_MID,
                    wr && paddr == OFS_EN_LOW};
    always_ff @(posedge mclk) begin
        src_q <= sources;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // a request may rise only after a source edge or an enable write
    sequence cause(int g);
        $past(grp_rise[g]) || $past(wr_en[g]) || $past(wr_en[g], 2);
    endsequence
    a_reset_clears: assert property (
        disable iff (1'b0) !rst_n |=> !(core_request_level_zero || core_request_level_one
        || core_request_level_two))
        else $error("request high after reset");
    a_high_rise_cause: assert property (
        $rose(core_request_level_zero) |-> cause(2))
        else $error("level zero request rose without cause");
    a_mid_rise_cause: assert property (
        $rose(core_request_level_one) |-> cause(1))
        else $error("level one request rose without cause");
    a_low_rise_cause: assert property (
        $rose(core_request_level_two) |-> cause(0))
        else $error("level two request rose without cause");
    a_req_fall_cause: assert property (
        $fell(core_request_level_zero) || $fell(core_request_level_one)
        || $fell(core_request_level_two) |-> $past(wr) || $past(wr, 2) || !$past(rst_n))
        else $error("request fell without a write");
    a_vector_fixed: assert property (
        take_pulse |-> vector_addr == (taken_level == 2'h0 ? VECTOR_LEVEL_ZERO
        : taken_level == 2'h1 ? VECTOR_LEVEL_ONE : VECTOR_LEVEL_TWO))
        else $error("vector does not match taken level");
    a_bus_answer: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not one cycle after setup");
    a_bus_error: assert property (
        pready |-> pslverr == (paddr > OFS_ACTIVE))
        else $error("bus error flag wrong for address");
endmodule

// [tb/three_level_irq_handler_tb_top.sv]
// self-checking bench for the handler and core end joined by the level link
`timescale 1ns/10ps
`define CHK(g, e) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("wrong value at %0t: got %h, expected %h", $time, g, e); \
        end \
    end
module three_level_irq_handler_tb_top;
    import irqh_pkg::*;
    logic mclk, rst_n, psel_h, psel_c, penable, pwrite, ret_pulse, take_pulse, er;
    logic pready_h, pready_c, pslverr_h, pslverr_c;
    logic [SRC_COUNT-1:0] src;
    logic [ADDR_WIDTH-1:0] paddr;
    logic [DATA_WIDTH-1:0] pwdata, prdata_h, prdata_c, rd;
    logic [15:0] vector_addr;
    logic [15:0] exp_vec;
    logic [1:0] taken_level;
    logic [2:0] lv;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    irqh_if lk();
    assign lv = {lk.core_request_level_zero, lk.core_request_level_one, lk.core_request_level_two};
    irqh_handler i_irqh_handler (
        .mclk, .rst_n, .link(lk), .sources(src), .psel(psel_h), .penable, .pwrite,
        .paddr, .pwdata, .prdata(prdata_h), .pready(pready_h), .pslverr(pslverr_h)
    );
    irqh_core i_irqh_core (
        .mclk, .rst_n, .link(lk), .ret_pulse, .take_pulse, .vector_addr, .taken_level,
        .in_service(), .psel(psel_c), .penable, .pwrite, .paddr, .pwdata,
        .prdata(prdata_c), .pready(pready_c), .pslverr(pslverr_c)
    );
    irqh_chk i_irqh_chk (
        .mclk, .rst_n, .core_request_level_zero(lk.core_request_level_zero),
        .core_request_level_one(lk.core_request_level_one),
        .core_request_level_two(lk.core_request_level_two), .sources(src), .psel(psel_h),
        .penable, .pwrite, .paddr, .pready(pready_h), .pslverr(pslverr_h), .take_pulse,
        .vector_addr, .taken_level
    );
    task automatic bus(input logic c, input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel_h <= ~c;
        psel_c <= c;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while ((c ? pready_c : pready_h) !== 1'b1);
        rd = c ? prdata_c : prdata_h;
        er = c ? pslverr_c : pslverr_h;
        psel_h <= 1'b0;
        psel_c <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic c, input logic [11:0] a, input logic [31:0] e);
        bus(c, 1'b0, a, DATA_ZERO);
        `CHK(rd, e)
    endtask
    task automatic pulse(input int n);
        @(posedge mclk);
        src[n] <= 1'b1;
        @(posedge mclk);
        src[n] <= 1'b0;
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        {rst_n, psel_h, psel_c, penable, pwrite, ret_pulse} = 6'h00;
        src = '0;
        paddr = '0;
        pwdata = DATA_ZERO;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rchk(1'b0, 12'(i * 4), i == 6 ? 32'(CODE_NONE) : DATA_ZERO);
        end
        `CHK(lv, LEVELS_RESET)
        $display("test reset values done");
        @(posedge mclk);
        src <= '1;
        @(posedge mclk);
        src <= '0;
        rchk(1'b0, OFS_FLAGS_LOW, DATA_ZERO);
        rchk(1'b0, OFS_CODE, 32'(CODE_NONE));
        for (int g = 0; g < 3; g++) begin
            bus(1'b0, 1'b1, OFS_EN_HIGH + 12'(4 * g), 32'h000000ff);
            rchk(1'b0, OFS_EN_HIGH + 12'(4 * g), 32'h000000ff);
        end
        $display("test disabled sources done");
        for (int n = 0; n < 24; n++) begin
            pulse(n);
            #1;
            `CHK(lv[n / 8], 1'b1)
            rchk(1'b0, 12'(8 - 4 * (n / 8)), (32'h2 << (n % 8)) - 32'h1);
            rchk(1'b0, OFS_CODE, 32'(n));
            rchk(1'b0, OFS_ACTIVE, (32'h2 << (n / 8)) - 32'h1);
        end
        $display("test source edges done");
        bus(1'b0, 1'b1, OFS_FLAGS_HIGH, DATA_ZERO);
        rchk(1'b0, OFS_FLAGS_HIGH, 32'h000000ff);
        bus(1'b0, 1'b1, OFS_FLAGS_HIGH, 32'h00000080);
        rchk(1'b0, OFS_FLAGS_HIGH, 32'h0000007f);
        rchk(1'b0, OFS_CODE, 32'h00000016);
        bus(1'b0, 1'b1, OFS_FLAGS_HIGH, 32'h000000ff);
        bus(1'b0, 1'b1, OFS_FLAGS_MID, 32'h000000ff);
        rchk(1'b0, OFS_CODE, 32'h00000007);
        rchk(1'b0, OFS_ACTIVE, 32'h00000001);
        `CHK(lv, 3'h1)
        bus(1'b0, 1'b1, OFS_EN_LOW, DATA_ZERO);
        repeat (2) @(posedge mclk);
        `CHK(lv, 3'h0)
        rchk(1'b0, OFS_FLAGS_LOW, 32'h000000ff);
        bus(1'b0, 1'b1, OFS_EN_LOW, 32'h000000ff);
        bus(1'b0, 1'b1, OFS_CODE, DATA_ZERO);
        rchk(1'b0, OFS_CODE, 32'h00000007);
        rchk(1'b0, 12'h020, DATA_ZERO);
        `CHK(er, 1'b1)
        $display("test clear and enable done");
        rchk(1'b1, OFS_CORE_STAT, 32'h00000007);
        bus(1'b1, 1'b1, OFS_CORE_MASK, 32'h00000007);
        for (int l = 0; l < 3; l++) begin
            for (int k = 0; k < 8 && take_pulse !== 1'b1; k++) @(posedge mclk);
            `CHK(take_pulse, 1'b1)
            `CHK(taken_level, 2'(l))
            exp_vec = l == 0 ? VECTOR_LEVEL_ZERO : l == 1 ? VECTOR_LEVEL_ONE : VECTOR_LEVEL_TWO;
            `CHK(vector_addr, exp_vec)
            rchk(1'b1, OFS_CORE_TAKEN, 32'h4 + 32'(l));
            bus(1'b1, 1'b1, OFS_CORE_STAT, 32'h1 << l);
            @(posedge mclk);
            ret_pulse <= 1'b1;
            @(posedge mclk);
            ret_pulse <= 1'b0;
        end
        rchk(1'b1, OFS_CORE_STAT, DATA_ZERO);
        `CHK(er, 1'b0)
        rchk(1'b1, 12'h00c, DATA_ZERO);
        `CHK(er, 1'b1)
        $display("test core levels done");
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        `CHK(lv, LEVELS_RESET)
        rchk(1'b0, OFS_FLAGS_LOW, DATA_ZERO);
        rchk(1'b0, OFS_EN_LOW, DATA_ZERO);
        $display("test mid-run reset done");
        test_done();
    end
endmodule
